// ==== include/status_command_pkg.sv ====
/*
 * Constants for the status/command configuration register: reset value,
 * write masks, field positions and event indices.
 * Assumes nothing of its surroundings; used by rtl/status_command_reg.sv.
 */
`default_nettype none
package status_command_pkg;
	// ------------------------------------------------------------
	// register image
	// ------------------------------------------------------------
	localparam logic [31:0] CFG_RESET = 32'h0290_0080;
	// write-one-to-clear flags, bits 31..27 and 24
	localparam logic [31:0] WC_MASK = 32'hF900_0000;
	// read/write from both buses, bits 8..6 and 2..0
	localparam logic [31:0] BOTH_MASK = 32'h0000_01C7;
	// read/write from the internal bus only, bits 22..21
	localparam logic [31:0] IB_MASK = 32'h0060_0000;
	// reserved, always zero, bits 19..10
	localparam logic [31:0] RSVD_MASK = 32'h000F_FC00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PARITY_ERROR_SEEN_BIT = 31;
	localparam int SYSTEM_ERROR_SIGNALLED_BIT = 30;
	localparam int MASTER_ABORT_RECEIVED_BIT = 29;
	localparam int TARGET_ABORT_RECEIVED_BIT = 28;
	localparam int TARGET_ABORT_SIGNALLED_BIT = 27;
	localparam int SELECT_TIMING_HIGH_BIT = 26;
	localparam int SELECT_TIMING_LOW_BIT = 25;
	localparam int DATA_PARITY_REPORTED_BIT = 24;
	localparam int FAST_B2B_CAPABLE_BIT = 23;
	localparam int POWER_MGMT_CAPABLE_BIT = 20;
	localparam int FAST_B2B_ENABLE_BIT = 9;
	localparam int SYSTEM_ERROR_OUTPUT_ENABLE_BIT = 8;
	localparam int STEPPING_ENABLE_BIT = 7;
	localparam int PARITY_RESPONSE_ENABLE_BIT = 6;
	localparam int BUS_MASTER_ENABLE_BIT = 2;
	localparam int MEMORY_SPACE_ENABLE_BIT = 1;
	localparam int IO_SPACE_ENABLE_BIT = 0;

	// ------------------------------------------------------------
	// events carried from the link domain, one toggle each
	// ------------------------------------------------------------
	localparam int EV_COUNT = 6;
	localparam int EV_PARITY = 0;
	localparam int EV_SERR = 1;
	localparam int EV_MABORT = 2;
	localparam int EV_TABORT_RX = 3;
	localparam int EV_TABORT_TX = 4;
	localparam int EV_DATA_PARITY = 5;

	// least phase hold in link clocks while stepping is on
	localparam int STEP_MIN_CLOCKS = 2;
endpackage
`default_nettype wire

// ==== rtl/status_command_reg.sv ====
/*
 * Status/command configuration register of a PCI controller, with the
 * controller-clock register image, an internal-bus write port, a PCI
 * configuration port on the link clock and event inputs from the link.
 * Assumes the transaction logic on the link clock raises single-cycle
 * event pulses and keeps phases itself; RST is shared by both domains.
 */
// Functional notes
// - reset loads 02900080 into whole register
// - flags 31..27, 24 clear on writing one
// - bits 31..27,24,8..6,2..0 writable from both
// - bits 22,21 writable from internal bus only
// - reserved bits 19..10 read zero, write zero
// - parity error sets flag regardless of response
// - asserting system error sets sticky flag
// - target abort received as master sets flag
// - target abort issued as target sets flag
// - select timing reads medium, bits 0 1
// - data parity flag set only with response
// - fast back-to-back capable reads fixed one
// - capability bits 22,21 reset to zero
// - power management capable reads fixed one
// - fast back-to-back enable reads fixed zero
// - system error pin driven only when enabled
// - stepping enable steers two-clock phase hold
// - parity error pin driven only when enabled
// - memory decode off makes memory accesses abort
// - io decode off makes io accesses abort
// - mastering only while bus master enable set
`timescale 1ns/1ns
`default_nettype none
module status_command_reg (
	// controller clock and reset
	input wire logic CLK,
	input wire logic RST,
	// internal peripheral bus port
	input wire logic IB_WR,
	input wire logic [31:0] IB_WDATA,
	output logic [31:0] IB_RDATA,
	// link clock
	input wire logic PCI_CLK,
	// PCI configuration access
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [31:0] CFG_WDATA,
	output logic [31:0] CFG_RDATA,
	output logic CFG_DONE,
	output logic CFG_BUSY,
	// transaction events on the link clock
	input wire logic PARITY_ERR_DET,
	input wire logic SERR_REQ,
	input wire logic PERR_REQ,
	input wire logic MASTER_ACTIVE,
	input wire logic MASTER_ABORT_EV,
	input wire logic TARGET_ABORT_RX_EV,
	input wire logic TARGET_ABORT_TX_EV,
	// error pins
	input wire logic PERR_N_IN,
	output logic PERR_N_OUT,
	output logic PERR_N_OE,
	output logic SERR_N_OUT,
	output logic SERR_N_OE,
	// command levels on the link clock, except B2B_DIFF_TARGET_EN from the controller-clock image
	output logic MASTER_EN,
	output logic MEM_DECODE_EN,
	output logic IO_DECODE_EN,
	output logic STEPPING_EN,
	output logic B2B_DIFF_TARGET_EN
);
	localparam int EVN = status_command_pkg::EV_COUNT;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cfg;
		logic [EVN-1:0] ev_s1;
		logic [EVN-1:0] ev_s2;
		logic [EVN-1:0] ev_s3;
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic ack_tgl;
		logic [31:0] hold;
	} core_t;

	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_WAIT = 2'b01,
		LK_DONE = 2'b11
	} link_state_t;

	typedef struct packed {
		link_state_t st;
		logic perr_s1;
		logic perr_s2;
		logic [5:0] cmd_s1;
		logic [5:0] cmd_s2;
		logic [EVN-1:0] ev_tgl;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_s3;
		logic wr;
		logic [31:0] wdata;
		logic [31:0] rdata;
	} link_t;

	core_t core_r, core_nxt;
	link_t link_r, link_nxt;

	// ------------------------------------------------------------
	// write merge: written bits under mask, stored bits elsewhere, then write-one-clear
	// ------------------------------------------------------------
	function automatic logic [31:0] apply_write(
		input logic [31:0] cur,
		input logic [31:0] wd,
		input logic [31:0] mask
	);
		logic [31:0] v;
		v = (cur & ~mask) | (wd & mask);
		v = v & ~(wd & status_command_pkg::WC_MASK);
		return v;
	endfunction

	// ------------------------------------------------------------
	// controller-clock domain
	// ------------------------------------------------------------
	logic [EVN-1:0] ev_edge;
	logic req_edge;
	logic [31:0] set_vec;
	logic [5:0] cmd_lvl;

	always_comb begin
		core_nxt = core_r;
		core_nxt.ev_s1 = link_r.ev_tgl;
		core_nxt.ev_s2 = core_r.ev_s1;
		core_nxt.ev_s3 = core_r.ev_s2;
		core_nxt.req_s1 = link_r.req_tgl;
		core_nxt.req_s2 = core_r.req_s1;
		core_nxt.req_s3 = core_r.req_s2;
		ev_edge = core_r.ev_s2 ^ core_r.ev_s3;
		req_edge = core_r.req_s2 ^ core_r.req_s3;
		set_vec = 32'h0000_0000;
		set_vec[status_command_pkg::PARITY_ERROR_SEEN_BIT] =
			ev_edge[status_command_pkg::EV_PARITY];
		set_vec[status_command_pkg::SYSTEM_ERROR_SIGNALLED_BIT] =
			ev_edge[status_command_pkg::EV_SERR];
		set_vec[status_command_pkg::MASTER_ABORT_RECEIVED_BIT] =
			ev_edge[status_command_pkg::EV_MABORT];
		set_vec[status_command_pkg::TARGET_ABORT_RECEIVED_BIT] =
			ev_edge[status_command_pkg::EV_TABORT_RX];
		set_vec[status_command_pkg::TARGET_ABORT_SIGNALLED_BIT] =
			ev_edge[status_command_pkg::EV_TABORT_TX];
		set_vec[status_command_pkg::DATA_PARITY_REPORTED_BIT] =
			ev_edge[status_command_pkg::EV_DATA_PARITY] &
			core_r.cfg[status_command_pkg::PARITY_RESPONSE_ENABLE_BIT];
		if (IB_WR) begin
			core_nxt.cfg = apply_write(core_nxt.cfg, IB_WDATA,
				status_command_pkg::BOTH_MASK |
				status_command_pkg::IB_MASK);
		end
		if (req_edge && link_r.wr) begin
			core_nxt.cfg = apply_write(core_nxt.cfg, link_r.wdata,
				status_command_pkg::BOTH_MASK);
		end
		// sets after clears so a same-cycle event survives
		core_nxt.cfg = core_nxt.cfg | set_vec;
		if (req_edge) begin
			core_nxt.hold = core_nxt.cfg;
			core_nxt.ack_tgl = ~core_r.ack_tgl;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			core_r <= '0;
			// fixed capability bits live only here, masks keep them
			core_r.cfg <= status_command_pkg::CFG_RESET;
		end else begin
			core_r <= core_nxt;
		end
	end

	assign IB_RDATA = core_r.cfg;
	assign cmd_lvl = {
		core_r.cfg[status_command_pkg::SYSTEM_ERROR_OUTPUT_ENABLE_BIT],
		core_r.cfg[status_command_pkg::PARITY_RESPONSE_ENABLE_BIT],
		core_r.cfg[status_command_pkg::STEPPING_ENABLE_BIT],
		core_r.cfg[status_command_pkg::BUS_MASTER_ENABLE_BIT],
		core_r.cfg[status_command_pkg::MEMORY_SPACE_ENABLE_BIT],
		core_r.cfg[status_command_pkg::IO_SPACE_ENABLE_BIT]
	};

	// ------------------------------------------------------------
	// link-clock domain
	// ------------------------------------------------------------
	logic serr_on, perr_on;
	logic serr_drive, perr_drive, perr_seen;
	logic ack_edge;
	logic [EVN-1:0] ev_in;

	always_comb begin
		serr_on = link_r.cmd_s2[5];
		perr_on = link_r.cmd_s2[4];
		serr_drive = SERR_REQ & serr_on;
		perr_drive = PERR_REQ & perr_on;
		perr_seen = MASTER_ACTIVE & ~link_r.perr_s2;
		ack_edge = link_r.ack_s2 ^ link_r.ack_s3;
		ev_in = '0;
		ev_in[status_command_pkg::EV_PARITY] = PARITY_ERR_DET;
		ev_in[status_command_pkg::EV_SERR] = serr_drive;
		ev_in[status_command_pkg::EV_MABORT] = MASTER_ABORT_EV;
		ev_in[status_command_pkg::EV_TABORT_RX] = TARGET_ABORT_RX_EV;
		ev_in[status_command_pkg::EV_TABORT_TX] = TARGET_ABORT_TX_EV;
		ev_in[status_command_pkg::EV_DATA_PARITY] =
			(MASTER_ACTIVE & perr_drive) | perr_seen;
		link_nxt = link_r;
		link_nxt.perr_s1 = PERR_N_IN;
		link_nxt.perr_s2 = link_r.perr_s1;
		link_nxt.cmd_s1 = cmd_lvl;
		link_nxt.cmd_s2 = link_r.cmd_s1;
		link_nxt.ack_s1 = core_r.ack_tgl;
		link_nxt.ack_s2 = link_r.ack_s1;
		link_nxt.ack_s3 = link_r.ack_s2;
		link_nxt.ev_tgl = link_r.ev_tgl ^ ev_in;
		case (link_r.st)
			LK_IDLE: begin
				if (CFG_WR || CFG_RD) begin
					link_nxt.wr = CFG_WR;
					link_nxt.wdata = CFG_WDATA;
					link_nxt.req_tgl = ~link_r.req_tgl;
					link_nxt.st = LK_WAIT;
				end
			end
			LK_WAIT: begin
				if (ack_edge) begin
					link_nxt.rdata = core_r.hold;
					link_nxt.st = LK_DONE;
				end
			end
			default: begin
				link_nxt.st = LK_IDLE;
			end
		endcase
	end

	always_ff @(posedge PCI_CLK or posedge RST) begin
		if (RST) begin
			link_r <= '0;
			link_r.perr_s1 <= 1'b1;
			link_r.perr_s2 <= 1'b1;
			link_r.st <= LK_IDLE;
		end else begin
			link_r <= link_nxt;
		end
	end

	assign CFG_RDATA = link_r.rdata;
	assign CFG_DONE = (link_r.st == LK_DONE);
	assign CFG_BUSY = (link_r.st != LK_IDLE);
	assign SERR_N_OUT = 1'b0;
	assign SERR_N_OE = serr_drive;
	assign PERR_N_OUT = 1'b0;
	assign PERR_N_OE = perr_drive;
	assign MASTER_EN = link_r.cmd_s2[2];
	assign MEM_DECODE_EN = link_r.cmd_s2[1];
	assign IO_DECODE_EN = link_r.cmd_s2[0];
	assign STEPPING_EN = link_r.cmd_s2[3];
	assign B2B_DIFF_TARGET_EN =
		core_r.cfg[status_command_pkg::FAST_B2B_ENABLE_BIT];

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	reset_value_a: assert property (
		@(posedge CLK) $fell(RST) |->
			IB_RDATA == status_command_pkg::CFG_RESET)
		else $error("register not at reset value after reset");

	reserved_zero_a: assert property (
		@(posedge CLK) disable iff (RST)
		(IB_RDATA & status_command_pkg::RSVD_MASK) == 32'h0000_0000)
		else $error("reserved bits read non-zero");

	fixed_bits_a: assert property (
		@(posedge CLK) disable iff (RST)
		IB_RDATA[26:25] == 2'b01 && IB_RDATA[23] && IB_RDATA[20] &&
		!IB_RDATA[9])
		else $error("fixed capability bits changed");

	write_clear_a: assert property (
		@(posedge CLK) disable iff (RST)
		IB_WR && IB_WDATA[31] && !req_edge &&
		!set_vec[31] |=> !IB_RDATA[31])
		else $error("write of one did not clear flag");

	set_wins_a: assert property (
		@(posedge CLK) disable iff (RST)
		set_vec[30] |=> IB_RDATA[30])
		else $error("event lost against clear");

	ib_only_a: assert property (
		@(posedge CLK) disable iff (RST)
		req_edge && link_r.wr && !IB_WR |=>
			IB_RDATA[22:21] == $past(IB_RDATA[22:21]))
		else $error("config write changed internal-only bits");

	dpd_gate_a: assert property (
		@(posedge CLK) disable iff (RST)
		!IB_RDATA[24] && !IB_RDATA[6] && !IB_WR && !req_edge |=>
			!IB_RDATA[24])
		else $error("data parity flag set with response off");

	parity_set_a: assert property (
		@(posedge PCI_CLK) disable iff (RST)
		PARITY_ERR_DET && !CFG_BUSY |-> ##[2:12] 1'b1 ##0
			core_r.cfg[31])
		else $error("parity flag not set after detection");

	serr_gate_a: assert property (
		@(posedge PCI_CLK) disable iff (RST)
		SERR_N_OE |-> link_r.cmd_s2[5])
		else $error("system error driven while disabled");

	perr_gate_a: assert property (
		@(posedge PCI_CLK) disable iff (RST)
		PERR_N_OE |-> link_r.cmd_s2[4] && PERR_REQ)
		else $error("parity error driven while disabled");

	cfg_done_a: assert property (
		@(posedge PCI_CLK) disable iff (RST)
		CFG_BUSY && !CFG_DONE |-> ##[1:20] CFG_DONE)
		else $error("config access did not complete");

	cfg_write_c: cover property (
		@(posedge PCI_CLK) disable iff (RST) CFG_WR ##[1:20] CFG_DONE);
	clear_c: cover property (
		@(posedge CLK) disable iff (RST) IB_RDATA[31] ##1 !IB_RDATA[31]);
	serr_c: cover property (
		@(posedge PCI_CLK) disable iff (RST) SERR_N_OE);
endmodule
`default_nettype wire

// ==== testbench/link_agent.sv ====
/*
 * Link-side model: configuration requests, event pulses and levels.
 * Assumes the register block's configuration port on pci_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module link_agent (
	// link clock
	input wire logic pci_clk,
	// configuration port
	input wire logic cfg_busy,
	input wire logic cfg_done,
	input wire logic [31:0] cfg_rdata,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [31:0] cfg_wdata,
	// parity, mabort, tabort rx, tabort tx, foreign perr low
	output logic [4:0] pulse_o,
	// master active, serr request, perr request
	output logic [2:0] level_o
);
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_wdata = 32'h0;
		pulse_o = 5'h0;
		level_o = 3'h0;
	end
	// --------------------------------------------------
	// transfers
	// --------------------------------------------------
	task automatic xfer(input logic wr, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h0;
		n = 0;
		@(negedge pci_clk);
		while (cfg_busy !== 1'b0 && n < 20) begin
			@(negedge pci_clk);
			n++;
		end
		cfg_wr <= wr;
		cfg_rd <= !wr;
		cfg_wdata <= d;
		@(negedge pci_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		// released data does not keep its value
		cfg_wdata <= ~d;
		// look mid-cycle, where the registered completion stands settled
		for (n = 0; n < 20 && !ok; n++) begin
			@(negedge pci_clk);
			if (cfg_done === 1'b1) begin
				q = cfg_rdata;
				ok = 1'b1;
			end
		end
	endtask
	task automatic pulse(input logic [4:0] p);
		@(negedge pci_clk);
		pulse_o <= p;
		@(negedge pci_clk);
		pulse_o <= 5'h0;
	endtask
	task automatic level(input logic [2:0] v);
		@(negedge pci_clk);
		level_o <= v;
	endtask
endmodule
`default_nettype wire

// ==== testbench/pci_status_command_register_tb.sv ====
/*
 * Self-checking bench for the status/command register.
 * Assumes status_command_reg and link_agent are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module pci_status_command_register_tb;
	localparam logic [31:0] WCM = 32'hF900_0000;
	localparam logic [31:0] BM = 32'h0000_01C7;
	localparam logic [31:0] IM = 32'h0060_0000;
	localparam logic [31:0] RV = 32'h0290_0080;
	logic clk = 1'b0;
	logic pci_clk = 1'b0;
	logic rst = 1'b1;
	logic ib_wr = 1'b0;
	logic [31:0] ib_wdata = 32'h0;
	logic [31:0] ib_rdata, cfg_rdata, cfg_wdata, exp_r, q;
	logic cfg_wr, cfg_rd, cfg_done, cfg_busy, ok;
	logic perr_oe, perr_out, serr_oe, serr_out;
	logic m_en, mem_en, io_en, step_en, b2b_en;
	logic [4:0] pls;
	logic [2:0] lvl;
	wire perr_n;
	int fails = 0;
	int num_checks = 0;
	int seed = 11;
	// pulled-up wire, low when driven or a foreign agent pulls it
	assign perr_n = perr_oe ? perr_out : !pls[4];
	always #25 clk = ~clk;
	always #15 pci_clk = ~pci_clk;
	status_command_reg DUT (.CLK(clk), .RST(rst), .IB_WR(ib_wr),
		.IB_WDATA(ib_wdata), .IB_RDATA(ib_rdata), .PCI_CLK(pci_clk),
		.CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_WDATA(cfg_wdata),
		.CFG_RDATA(cfg_rdata), .CFG_DONE(cfg_done), .CFG_BUSY(cfg_busy),
		.PARITY_ERR_DET(pls[0]), .SERR_REQ(lvl[1]), .PERR_REQ(lvl[2]),
		.MASTER_ACTIVE(lvl[0]), .MASTER_ABORT_EV(pls[1]),
		.TARGET_ABORT_RX_EV(pls[2]), .TARGET_ABORT_TX_EV(pls[3]),
		.PERR_N_IN(perr_n), .PERR_N_OUT(perr_out), .PERR_N_OE(perr_oe),
		.SERR_N_OUT(serr_out), .SERR_N_OE(serr_oe), .MASTER_EN(m_en),
		.MEM_DECODE_EN(mem_en), .IO_DECODE_EN(io_en),
		.STEPPING_EN(step_en), .B2B_DIFF_TARGET_EN(b2b_en));
	link_agent agent (.pci_clk(pci_clk), .cfg_busy(cfg_busy),
		.cfg_done(cfg_done), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .pulse_o(pls),
		.level_o(lvl));
	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] c, w, m);
		return ((c & ~(w & WCM)) & ~m) | (w & m);
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic ib_write(input logic [31:0] w);
		@(negedge clk);
		ib_wr = 1'b1;
		ib_wdata = w;
		@(negedge clk);
		ib_wr = 1'b0;
		ib_wdata = ~w;
		exp_r = nxt(exp_r, w, BM | IM);
		@(negedge clk);
		chk(ib_rdata, exp_r, "ib write");
	endtask
	task automatic cfg_write(input logic [31:0] w);
		agent.xfer(1'b1, w, q, ok);
		exp_r = nxt(exp_r, w, BM);
		@(negedge clk);
		chk({31'h0, ok}, 32'h1, "cfg done");
		chk(q, exp_r, "cfg data");
		chk(ib_rdata, exp_r, "cfg image");
	endtask
	task automatic chk_cmd();
		repeat (4) @(negedge pci_clk);
		chk({27'h0, m_en, mem_en, io_en, step_en, b2b_en},
			{27'h0, exp_r[2], exp_r[1], exp_r[0], exp_r[7], 1'b0},
			"cmd");
		chk({31'h0, cfg_busy}, 32'h0, "cfg idle");
	endtask
	task automatic settle(input logic [31:0] s);
		repeat (8) @(negedge clk);
		exp_r = exp_r | s;
		chk(ib_rdata, exp_r, "flags");
	endtask
	// --------------------------------------------------
	// tests
	// --------------------------------------------------
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		exp_r = RV;
		@(negedge clk);
		chk(ib_rdata, RV, "reset");
		chk_cmd();
		agent.xfer(1'b0, 32'h0, q, ok);
		chk({31'h0, ok}, 32'h1, "cfg read done");
		chk(q, RV, "cfg read");
		$display("test reset done");
		ib_write(32'h0000_01C7);
		ib_write(32'hFFF0_03FF);
		cfg_write(32'hFFF0_0000);
		for (int i = 0; i < 8; i++) begin
			ib_write($random(seed) & 32'hFFF0_03FF);
			cfg_write($random(seed) & 32'hFFF0_03FF);
			chk_cmd();
		end
		$display("test writes done");
		for (int k = 0; k < 4; k++) begin
			agent.pulse(5'h1 << k);
			settle(32'h1 << ((k == 0) ? 31 : 30 - k));
		end
		cfg_write(32'h0000_0000);
		ib_write(32'h8000_0000);
		cfg_write(32'h1000_0000);
		$display("test flags done");
		agent.level(3'b111);
		agent.pulse(5'h10);
		settle(32'h0);
		chk({30'h0, perr_oe, serr_oe}, 32'h0, "oe off");
		ib_write(32'h0000_0140);
		settle(32'h4100_0000);
		chk({30'h0, perr_oe, serr_oe}, 32'h3, "oe on");
		chk({30'h0, perr_out, serr_out}, 32'h0, "pins low");
		agent.level(3'b000);
		settle(32'h0);
		cfg_write(32'h4100_0140);
		$display("test errors done");
		end_of_test();
	end
endmodule
`default_nettype wire
